// ### rtl/wdog_params.svh
`ifndef WDOG_PARAMS_SVH
`define WDOG_PARAMS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_IE0      8'ha8
`define IDX_PRIO     8'ha9
`define IDX_IE1      8'hb8
`define IDX_RELOAD   8'h86

// ==========================================================
// Field positions
`define BIT_ARM      6
`define BIT_START    6
`define BIT_WD_FLAG  6
`define BIT_OSC_FLAG 7
`define BIT_PRESEL   7

// ==========================================================
// Reset values
`define SFR_RST      8'h00
`define RELOAD_RST   8'h00
`define IP_LOW_RST   6'h00
`define COUNT_RST    15'h0000
`define PRE_RST      5'h00
`define RCNT_RST     8'h00

// ==========================================================
// Timing counts
`define WD_TIMEOUT   15'h7ffc
`define PRE_SHORT    5'h01
`define PRE_LONG     5'h1f
`define RST_SHORT    8'h08
`define RST_LONG     8'h80
`define ARM_LAST     2'h1
`define OSC_HOLD     2'h3
`define OSC_MIN      8'h01

`endif

// ### rtl/wdog_pkg.sv
package wdog_pkg;

    // ==========================================================
    // Bus carriers
    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } av_rsp_t;

    // ==========================================================
    // Watchdog states and counter
    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,
        WD_RUN   = 2'b01,
        WD_RESET = 2'b10
    } wd_state_t;

    typedef logic [14:0] wd_count_t;

endpackage

// ### rtl/osc_monitor.sv
`timescale 1ns/1ps
`include "wdog_params.svh"
module osc_monitor #(
    parameter int               WIN_W     = 8,
    parameter logic [WIN_W-1:0] MIN_TICKS = `OSC_MIN
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Monitor inputs
    input  wire logic enable,
    input  wire logic osc_tick,
    input  wire logic rc_tick,
    // Results
    output logic      osc_reset_q,
    output logic      fail_event_q
);
    logic [WIN_W-1:0] cnt_q;
    logic             fail_q;
    logic             valid_q;
    logic [1:0]       hold_q;
    logic             too_slow;

    assign too_slow = cnt_q < MIN_TICKS;

    // ==========================================================
    // Raw oscillator ticks per reference window
    // raw oscillator compared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!enable || rc_tick) begin
            cnt_q <= '0;
        end else if (osc_tick && cnt_q != '1) begin
            cnt_q <= cnt_q + WIN_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fail_q       <= 1'b0;
            fail_event_q <= 1'b0;
        end else if (!enable) begin
            fail_q       <= 1'b0;
            fail_event_q <= 1'b0;
        end else begin
            fail_event_q <= rc_tick & valid_q & too_slow & ~fail_q;
            if (rc_tick && valid_q) begin
                fail_q <= too_slow;
            end
        end
    end

    // First window after reset or enable is partial; judging it
    // would report a false failure
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
        end else if (!enable) begin
            valid_q <= 1'b0;
        end else if (rc_tick) begin
            valid_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q <= 2'h0;
        end else if (!enable) begin
            hold_q <= 2'h0;
        end else if (fail_q) begin
            hold_q <= `OSC_HOLD;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_reset_q <= 1'b0;
        end else begin
            osc_reset_q <= enable & (fail_q | (hold_q != 2'h0));
        end
    end

    osc_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $fell(fail_q) && enable |-> osc_reset_q [*3])
        else $error("oscillator reset released early");

    osc_enable_off_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !enable |=> !osc_reset_q && !fail_event_q)
        else $error("oscillator monitor active while disabled");

endmodule

// ### rtl/fail_safe_watchdog.sv
`timescale 1ns/1ps
`include "wdog_params.svh"
module fail_safe_watchdog (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Avalon-MM slave
    input  wire wdog_pkg::av_req_t av_req,
    output wdog_pkg::av_rsp_t      av_rsp,
    // Pins
    input  wire logic              powersave_autostart_pin,
    input  wire logic              osc_monitor_enable_pin,
    input  wire logic              osc_tick,
    input  wire logic              rc_tick,
    // Reset outputs
    output logic                   sys_reset_q,
    output logic                   port_force_ones_q
);
    import wdog_pkg::*;

    // ==========================================================
    // Declarations
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [7:0]  rbyte;
    logic        req;
    logic        accept;
    logic        wr_lane;
    logic        wr_ie0;
    logic        wr_ie1;
    logic        wr_prio;
    logic        wr_rel;
    logic [7:0]  wdata;
    logic [7:0]  ie0_q;
    logic [1:0]  arm_age_q;
    logic [7:0]  ie1_q;
    logic [5:0]  ip_low_q;
    logic        wd_timeout_flag_q;
    logic        osc_fail_flag_q;
    logic [7:0]  wd_reload_reg_q;
    logic [6:0]  reload_val;
    logic        boot_q;
    wd_state_t   state_q;
    wd_state_t   state_d;
    logic        load;
    logic        start_wr;
    logic        refresh;
    logic        wd_enter;
    wd_count_t   count_q;
    logic [4:0]  pre_q;
    logic [4:0]  pre_lim;
    logic [7:0]  rst_cnt_q;
    logic        osc_rst;
    logic        osc_fail_evt;
    logic        int_rst;
    logic        running;

    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        return (a[9:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    // ==========================================================
    // Bus handshake: one wait cycle per access
    assign req    = av_req.read | av_req.write;
    assign accept = req & ~wait_q;
    assign av_rsp = '{readdata: rdata_q, waitrequest: wait_q};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // Writes are dropped while any internal reset holds the chip
    assign int_rst = (state_q == WD_RESET) | osc_rst;
    assign wdata   = av_req.writedata[7:0];
    assign wr_lane = accept & av_req.write & av_req.byteenable[0] & ~int_rst;
    assign wr_ie0  = wr_lane & hit(av_req.address, `IDX_IE0);
    assign wr_ie1  = wr_lane & hit(av_req.address, `IDX_IE1);
    assign wr_prio = wr_lane & hit(av_req.address, `IDX_PRIO);
    assign wr_rel  = wr_lane & hit(av_req.address, `IDX_RELOAD);
    assign running = state_q != WD_IDLE;

    always_comb begin
        rbyte = 8'h00;
        if (hit(av_req.address, `IDX_IE0)) begin
            rbyte = ie0_q;
        end else if (hit(av_req.address, `IDX_IE1)) begin
            rbyte = ie1_q;
            rbyte[`BIT_START] = running;
        end else if (hit(av_req.address, `IDX_PRIO)) begin
            rbyte = {osc_fail_flag_q, wd_timeout_flag_q, ip_low_q};
        end else if (hit(av_req.address, `IDX_RELOAD)) begin
            rbyte = wd_reload_reg_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && wait_q) begin
            rdata_q <= {24'h00_0000, rbyte};
        end
    end

    // ==========================================================
    // Arm bit with automatic clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie0_q     <= `SFR_RST;
            arm_age_q <= 2'h0;
        end else if (int_rst) begin
            ie0_q     <= `SFR_RST;
            arm_age_q <= 2'h0;
        end else if (wr_ie0) begin
            ie0_q     <= wdata;
            arm_age_q <= 2'h0;
        end else if (ie0_q[`BIT_ARM]) begin
            if (arm_age_q == `ARM_LAST) begin
                ie0_q[`BIT_ARM] <= 1'b0;
            end
            arm_age_q <= arm_age_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie1_q <= `SFR_RST;
        end else if (int_rst) begin
            ie1_q <= `SFR_RST;
        end else if (wr_ie1) begin
            ie1_q <= wdata;
        end
    end

    // ==========================================================
    // Status flags: hardware set wins over a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ip_low_q <= `IP_LOW_RST;
        end else if (int_rst) begin
            ip_low_q <= `IP_LOW_RST;
        end else if (wr_prio) begin
            ip_low_q <= wdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_timeout_flag_q <= 1'b0;
        end else if (wd_enter) begin
            wd_timeout_flag_q <= 1'b1;
        end else if (wr_prio) begin
            wd_timeout_flag_q <= wdata[`BIT_WD_FLAG];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_fail_flag_q <= 1'b0;
        end else if (osc_fail_evt) begin
            osc_fail_flag_q <= 1'b1;
        end else if (wr_prio) begin
            osc_fail_flag_q <= wdata[`BIT_OSC_FLAG];
        end
    end

    // ==========================================================
    // Reload register
    // writable except while an internal reset holds the chip
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_reload_reg_q <= `RELOAD_RST;
        end else if (wd_enter || int_rst) begin
            wd_reload_reg_q <= `RELOAD_RST;
        end else if (wr_rel) begin
            wd_reload_reg_q <= wdata;
        end
    end

    assign reload_val = wd_reload_reg_q[6:0];

    // ==========================================================
    // Watchdog state machine
    // Strap sampled on the first edge after release, never under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    assign start_wr = wr_ie1 & wdata[`BIT_START];
    assign refresh  = start_wr & ie0_q[`BIT_ARM];

    always_comb begin
        state_d = state_q;
        load    = 1'b0;
        case (state_q)
            WD_IDLE: begin
                if ((boot_q && powersave_autostart_pin) || start_wr) begin
                    state_d = WD_RUN;
                    load    = 1'b1;
                end
            end
            WD_RUN: begin
                if (count_q == `WD_TIMEOUT) begin
                    state_d = WD_RESET;
                end else if (refresh) begin
                    load = 1'b1;
                end
            end
            WD_RESET: begin
                if (rst_cnt_q == 8'h01) begin
                    state_d = WD_RUN;
                end
            end
            default: begin
                state_d = WD_IDLE;
            end
        endcase
    end

    assign wd_enter = (state_q == WD_RUN) && (state_d == WD_RESET);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= WD_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Prescaler and 15-bit counter
    // extra divide-by-16
    assign pre_lim = wd_reload_reg_q[`BIT_PRESEL] ? `PRE_LONG : `PRE_SHORT;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `COUNT_RST;
            pre_q   <= `PRE_RST;
        end else if (load) begin
            count_q <= {reload_val, 8'h00};
            pre_q   <= `PRE_RST;
        end else if (state_q != WD_RUN || wd_enter) begin
            count_q <= `COUNT_RST;
            pre_q   <= `PRE_RST;
        end else if (pre_q == pre_lim) begin
            count_q <= count_q + 15'h0001;
            pre_q   <= `PRE_RST;
        end else begin
            pre_q   <= pre_q + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_q <= `RCNT_RST;
        end else if (wd_enter) begin
            rst_cnt_q <= wd_reload_reg_q[`BIT_PRESEL] ? `RST_LONG : `RST_SHORT;
        end else if (state_q == WD_RESET) begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
        end
    end

    // ==========================================================
    // Oscillator monitor and reset outputs
    osc_monitor u_osc (
        .clk          (clk),
        .rst_n        (rst_n),
        .enable       (osc_monitor_enable_pin),
        .osc_tick     (osc_tick),
        .rc_tick      (rc_tick),
        .osc_reset_q  (osc_rst),
        .fail_event_q (osc_fail_evt)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_reset_q       <= 1'b0;
            port_force_ones_q <= 1'b0;
        end else begin
            sys_reset_q       <= (state_d == WD_RESET) | osc_rst;
            port_force_ones_q <= osc_rst;
        end
    end

    // ==========================================================
    // Checks
    sequence arm_set_s;
        $rose(ie0_q[`BIT_ARM]);
    endsequence

    sequence arm_life_s;
        ie0_q[`BIT_ARM] ##1 !ie0_q[`BIT_ARM];
    endsequence

    arm_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        arm_set_s |-> ##1 arm_life_s)
        else $error("arm bit did not clear in second cycle");

    start_load_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_IDLE && start_wr |=>
        state_q == WD_RUN && count_q == {$past(reload_val), 8'h00})
        else $error("start did not load reload value");

    refresh_load_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_RUN && refresh && count_q != `WD_TIMEOUT |=>
        count_q == {$past(reload_val), 8'h00} && pre_q == `PRE_RST)
        else $error("refresh did not reload counter");

    no_refresh_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_RUN && start_wr && !ie0_q[`BIT_ARM] && pre_q != pre_lim
        && count_q != `WD_TIMEOUT |=> $stable(count_q))
        else $error("start without arm refreshed counter");

    no_stop_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q != WD_IDLE |=> state_q != WD_IDLE)
        else $error("running watchdog stopped");

    timeout_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_RUN && count_q == `WD_TIMEOUT |=>
        state_q == WD_RESET && sys_reset_q && wd_timeout_flag_q)
        else $error("timeout did not enter reset");

    rst_len_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wd_enter |=> rst_cnt_q ==
        ($past(wd_reload_reg_q[`BIT_PRESEL]) ? `RST_LONG : `RST_SHORT))
        else $error("wrong watchdog reset length");

    rst_exit_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_RESET && rst_cnt_q == 8'h01 |=> state_q == WD_RUN)
        else $error("watchdog reset did not return to running");

    reload_clr_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_RESET |-> wd_reload_reg_q == `RELOAD_RST)
        else $error("reload not cleared by watchdog reset");

    count_rate_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == WD_RUN && !load && !wd_enter && pre_q == pre_lim
        |=> count_q == $past(count_q) + 15'h0001)
        else $error("counter did not step at prescaler end");

    autostart_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        boot_q && !powersave_autostart_pin && !start_wr |=> state_q == WD_IDLE)
        else $error("watchdog started without strap");

    ports_high_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        osc_rst |=> port_force_ones_q && sys_reset_q)
        else $error("ports not forced high in monitor reset");

    osc_flag_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        osc_fail_evt |=> osc_fail_flag_q)
        else $error("oscillator flag not set on failure");

endmodule

// ### test/cpu_bus_model.sv
`timescale 1ns/1ps
// ==========================================================
// Software side of the register bus
module cpu_bus_model
    import wdog_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Bus
    output wdog_pkg::av_req_t      av_req,
    input  wire wdog_pkg::av_rsp_t av_rsp
);
    import wdog_pkg::*;

    logic held;

    initial begin
        av_req = '0;
        held   = 1'b0;
    end

    // ==========================================================
    // One access; hold keeps the strobe up for a chained access
    // arm and start issued as back-to-back accesses
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
                        input logic h, output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        if (!held) @(posedge clk);
        av_req.read       <= ~w;
        av_req.write      <= w;
        av_req.address    <= {i, 2'b00};
        av_req.byteenable <= 4'hf;
        // Upper lanes random; the block ignores them
        av_req.writedata  <= {24'($urandom), d};
        do begin
            @(posedge clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 50);
        q    = av_rsp.readdata[7:0];
        ok   = (av_rsp.waitrequest === 1'b0);
        held = h;
        if (!h) begin
            av_req.read  <= 1'b0;
            av_req.write <= 1'b0;
        end
    endtask
endmodule

// ### test/tb_program_and_oscillator_watchdog.sv
`timescale 1ns/1ps
module tb_program_and_oscillator_watchdog;
    import wdog_pkg::*;

    // ==========================================================
    // Stimulus, observation and model state
    logic       clk       = 1'b0;
    logic       rst_n     = 1'b0;
    logic       autostart = 1'b0;
    logic       osc_en    = 1'b1;
    logic       osc_run   = 1'b1;
    logic       osc_tick  = 1'b0;
    logic       rc_tick   = 1'b0;
    logic [3:0] rc_cnt    = 4'h0;
    logic       sys_reset_q;
    logic       port_force_ones_q;
    av_req_t    av_req;
    av_rsp_t    av_rsp;
    int         err_total = 0;
    int         tests_run = 0;
    int         run       = 0;
    int         n;
    int         k;
    int         m[int];
    logic [7:0] regs[5]   = '{8'ha8, 8'ha9, 8'hb8, 8'h86, 8'h10};

    initial begin
        forever #12.5 clk = ~clk;
    end

    // raw oscillator ticks, not a divided clock
    always @(posedge clk) begin
        osc_tick <= osc_run & ~osc_tick;
        rc_cnt   <= rc_cnt + 4'h1;
        rc_tick  <= (rc_cnt == 4'hf);
    end

    fail_safe_watchdog uut (
        .clk(clk), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp),
        .powersave_autostart_pin(autostart), .osc_monitor_enable_pin(osc_en),
        .osc_tick(osc_tick), .rc_tick(rc_tick),
        .sys_reset_q(sys_reset_q), .port_force_ones_q(port_force_ones_q)
    );

    cpu_bus_model cpu (.clk(clk), .av_req(av_req), .av_rsp(av_rsp));

    // ==========================================================
    // Checking and bus helpers
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
        tests_run++;
        if ((g + t >= e && g <= e + t) !== 1'b1) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic h);
        logic [7:0] q;
        logic       ok;
        int         e;
        cpu.xfer(w, i, d, h, q, ok);
        if (!ok) begin
            err_total++;
            $display("ERROR waitrequest expected 0 seen 1");
            tally_and_finish();
        end else begin
            e = m.exists(i) ? m[i] : 0;
            if (i == 8'hb8) e = (e & 'hbf) | (run << 6);
            if (!w) begin
                chk("readdata", e, q, 0);
            end else if (i inside {8'ha8, 8'ha9, 8'hb8, 8'h86}) begin
                // Arm bit never reads back once it has cleared itself
                m[i] = (i == 8'ha8) ? (d & 'hbf) : d;
                if (i == 8'hb8 && d[6]) run = 1;
            end
        end
    endtask

    task automatic hw_reset(input logic pin);
        rst_n     <= 1'b0;
        autostart <= pin;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        m.delete();
        run = pin;
        @(posedge clk);
    endtask

    // Waits for the watchdog reset, then times its pulse
    task automatic wd_timeout(input logic [7:0] rel);
        int c;
        int len;
        // count rate of two or thirty-two cycles a step
        c = (32'h7ffc - (32'(rel[6:0]) << 8)) * (rel[7] ? 32 : 2);
        n = 0;
        while (sys_reset_q !== 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        chk("timeout period", c, n, rel[7] ? 34 : 4);
        if (n >= 9000) tally_and_finish();
        len = 0;
        while (sys_reset_q === 1'b1 && len < 200) begin
            @(posedge clk);
            len++;
        end
        chk("reset pulse", rel[7] ? 128 : 8, len, 0);
        if (len >= 200) tally_and_finish();
        m[8'h86] = 0;
        m[8'ha8] = 0;
        m[8'hb8] = 0;
        m[8'ha9] = (m.exists(8'ha9) ? (m[8'ha9] & 'h80) : 0) | 'h40;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'he9a15b23));
        hw_reset(1'b0);
        foreach (regs[k]) bus(1'b0, regs[k], 8'h00, 1'b0);
        bus(1'b1, 8'h10, 8'h5a, 1'b0);
        bus(1'b0, 8'h10, 8'h00, 1'b0);
        $display("test reset values done");

        bus(1'b1, 8'h86, 8'h7f, 1'b0);
        bus(1'b1, 8'hb8, 8'h40, 1'b0);
        wd_timeout(8'h7f);
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        bus(1'b0, 8'h86, 8'h00, 1'b0);
        bus(1'b0, 8'hb8, 8'h00, 1'b0);
        $display("test start and timeout done");

        bus(1'b1, 8'h86, 8'h7f, 1'b0);
        bus(1'b1, 8'hb8, 8'h40, 1'b0);
        bus(1'b1, 8'hb8, 8'h40, 1'b0);
        // Start without arm must not reload; a reload would time out here
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (sys_reset_q !== 1'b0) n++;
        end
        chk("start without arm", 0, n, 0);
        bus(1'b1, 8'ha8, 8'h40, 1'b1);
        bus(1'b1, 8'hb8, 8'h40, 1'b0);
        wd_timeout(8'h7f);
        bus(1'b1, 8'ha8, 8'h40, 1'b0);
        repeat (3) @(posedge clk);
        bus(1'b0, 8'ha8, 8'h00, 1'b0);
        $display("test refresh done");

        bus(1'b1, 8'h86, 8'hff, 1'b0);
        bus(1'b1, 8'ha8, 8'h40, 1'b1);
        bus(1'b1, 8'hb8, 8'h40, 1'b0);
        wd_timeout(8'hff);
        bus(1'b1, 8'ha9, 8'h00, 1'b0);
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        bus(1'b1, 8'ha9, 8'h40, 1'b0);
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        $display("test prescaler and flag done");

        hw_reset(1'b0);
        bus(1'b0, 8'hb8, 8'h00, 1'b0);
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        autostart <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, 8'hb8, 8'h00, 1'b0);
        $display("test stop by reset done");

        osc_run <= 1'b0;
        n = 0;
        while (port_force_ones_q !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("osc reset", 1, sys_reset_q, 0);
        chk("ports high", 1, port_force_ones_q, 0);
        if (n >= 60) tally_and_finish();
        osc_run <= 1'b1;
        n = 0;
        k = 0;
        while (port_force_ones_q !== 1'b0 && n < 80) begin
            @(posedge clk);
            n++;
            k = (rc_tick === 1'b1) ? 0 : k + 1;
        end
        // Good window closes at the last reference tick; three hold
        // cycles and two register stages follow before release
        chk("osc recovery", 16, n, 8);
        chk("osc hold", 6, k, 0);
        if (n >= 80) tally_and_finish();
        m[8'ha9] = 'h80;
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        bus(1'b1, 8'ha9, 8'h00, 1'b0);
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        bus(1'b1, 8'ha9, 8'h80, 1'b0);
        bus(1'b0, 8'ha9, 8'h00, 1'b0);
        $display("test oscillator monitor done");

        osc_en  <= 1'b0;
        osc_run <= 1'b0;
        n = 0;
        repeat (64) begin
            @(posedge clk);
            if (port_force_ones_q !== 1'b0) n++;
        end
        chk("monitor off", 0, n, 0);
        osc_run <= 1'b1;
        osc_en  <= 1'b1;
        $display("test monitor disable done");

        hw_reset(1'b1);
        bus(1'b0, 8'hb8, 8'h00, 1'b0);
        $display("test autostart done");
        tally_and_finish();
    end
endmodule
